// ==== src/iopm_pkg.sv ====
/*
 * iopm_pkg: shared constants and types of the IO stack performance monitor:
 * register word indices, control field layout, event select codes and the
 * packed structs for event inputs and module state.
 * Assumes a 32-bit classic Wishbone register bus with word addressing.
 */
package iopm_pkg;

   // sizes
   localparam int NUM_CTR = 4;
   localparam int NUM_PORTS = 8;
   localparam int CTR_W = 48;
   localparam int BW_W = 36;
   localparam int INC_W = 11;
   localparam int BW_BYTES_W = 7;
   localparam int BW_UNIT_LOG2 = 5;

   // register word indices (byte address = 4 * index)
   localparam logic [6:0] IDX_CTL = 7'h00;
   localparam logic [6:0] IDX_CTR = 7'h08;
   localparam logic [6:0] IDX_IOCLK = 7'h10;
   localparam logic [6:0] IDX_BWIN = 7'h20;
   localparam logic [6:0] IDX_BWOUT = 7'h30;
   localparam logic [6:0] IDX_STATUS = 7'h40;

   // control register field layout and write mask
   localparam int EVSEL_LSB = 0;
   localparam int EVSEL_W = 8;
   localparam int EN_BIT = 22;
   localparam int THR_LSB = 24;
   localparam int THR_W = 12;
   localparam int CH_LSB = 36;
   localparam int CH_W = 12;
   localparam int FC_LSB = 48;
   localparam int FC_W = 3;
   localparam logic [63:0] CTL_WMASK = 64'h0007_FFFF_FFFF_FFFF;
   localparam logic [63:0] CTL_RESET = 64'h0000_0000_0000_0000;
   localparam int STATUS_PD_BIT = 0;

   // event select codes
   localparam logic [7:0] EV_DBG_AND = 8'h02;
   localparam logic [7:0] EV_DBG_OR = 8'h03;
   localparam logic [7:0] EV_NOTHING = 8'h80;
   localparam logic [7:0] EV_CLOCKS = 8'h81;
   localparam logic [7:0] EV_INB_DATA = 8'h83;
   localparam logic [7:0] EV_INB_TXN = 8'h84;
   localparam logic [7:0] EV_INB_REQ = 8'h85;
   localparam logic [7:0] EV_ARB_REQ = 8'h86;
   localparam logic [7:0] EV_ARB_WON = 8'h87;
   localparam logic [7:0] EV_PASS_CMPL = 8'h90;
   localparam logic [7:0] EV_CL_CMPL = 8'h91;
   localparam logic [7:0] EV_REQ_CMPL = 8'h92;
   localparam logic [7:0] EV_OUTB_DATA = 8'hC0;
   localparam logic [7:0] EV_CBUF_INS = 8'hC2;
   localparam logic [7:0] EV_OUTQ_OCC = 8'hC5;
   localparam logic [7:0] EV_LINE_REQ = 8'hD0;
   localparam logic [7:0] EV_PKT_REQ = 8'hD1;
   localparam logic [7:0] EV_CBUF_OCC = 8'hD5;

   // per-cycle event inputs from the traffic controller, same clock
   typedef struct packed {
      logic [INC_W-1:0] inbound_data_request_event;
      logic inbound_transaction_event;
      logic inbound_request_count_event;
      logic ingress_arbitration_event;
      logic ingress_grant_event;
      logic pass_done_event;
      logic line_done_event;
      logic pcie_request_done_event;
      logic [INC_W-1:0] outbound_data_request_event;
      logic cbuf_insert_event;
      logic [8:0] outbound_queue_occupancy_event;
      logic egress_line_request_event;
      logic egress_packet_request_event;
      logic [8:0] cbuf_occupancy_event;
      logic dbg_and_match;
      logic dbg_or_match;
      logic [1:0] flow_class;
      logic [3:0] channel;
   } iopm_events_t;

   // whole state of the monitor
   typedef struct packed {
      logic [NUM_CTR-1:0][63:0] ctl;
      logic [NUM_CTR-1:0][CTR_W-1:0] ctr;
      logic [CTR_W-1:0] ioclk;
      logic [NUM_PORTS-1:0][BW_W-1:0] bw_in;
      logic [NUM_PORTS-1:0][BW_W-1:0] bw_out;
      logic [NUM_PORTS-1:0][BW_UNIT_LOG2-1:0] rem_in;
      logic [NUM_PORTS-1:0][BW_UNIT_LOG2-1:0] rem_out;
      logic pd_meta;
      logic pd;
      logic ack;
      logic [31:0] dat;
   } iopm_state_t;

endpackage

// ==== src/iopm_monitor.sv ====
/*
 * iopm_monitor: IO stack performance monitor with four programmable 48-bit
 * event counters, a free-running IO clock counter and per-port inbound and
 * outbound bandwidth counters, all reached over a classic Wishbone slave.
 * Assumes event inputs arrive on CLK from the traffic controller and that
 * STACK_POWER_DOWN comes from another domain and is synchronised here.
 */
// What this block does
// RULE1: four programmable 48-bit counters, any permitted event
// RULE2: counter accepts a multi-bit increment each cycle
// RULE3: flow-class field selects posted, non-posted, completions
// RULE4: channel mask field restricts counting to channels
// RULE5: threshold field gates counting by increment size
// RULE6: software writes zeros to reserved control bits
// RULE7: free-running counters ignore software writes
// RULE8: counting holds while the stack is powered down
// RULE9: IO clock counter, 48 bits, one per clock
// RULE10: inbound counter advances per 32 bytes
// RULE11: outbound counter advances per 32 bytes
// RULE12: bandwidth counters read-only 36 bits, reset zero
// RULE13: event 0x81 counts clocks on any counter
// RULE14: event 0x83 inbound data, counters 0-1 only
// RULE15: event 0xc0 outbound data, counters 2-3 only
// RULE16: event 0xc5 outbound queue occupancy, counters 2-3
// RULE17: events 0x86, 0x87 arbitration requests and grants
// RULE18: events 0xd0, 0xd1 outbound line and packet requests
// RULE19: 0xd5 completion occupancy on 2-3; 0xc2 inserts
// RULE20: events 0x02, 0x03 debug match, counters 0-1
// RULE21: events 0x90-0x92 PCIe request completion stages
// RULE22: events 0x84, 0x85 inbound transactions and requests
// RULE23: clock event advances once per controller clock
// RULE24: counters add increment and wrap modulo 2^48
// RULE25: forbidden event on a counter never increments
`timescale 1ns/1ns
`default_nettype none

module iopm_monitor #(
   parameter int NUM_CTR = 4,
   parameter int NUM_PORTS = 8
) (
   input wire logic CLK,
   input wire logic RESET,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [8:2] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   input wire iopm_pkg::iopm_events_t EVENTS,
   input wire logic [NUM_PORTS-1:0][6:0] BW_IN_BYTES,
   input wire logic [NUM_PORTS-1:0][6:0] BW_OUT_BYTES,
   input wire logic STACK_POWER_DOWN,
   output logic STACK_POWERED_DOWN
);

   // the state struct is sized by the package, so only those values are served
   if (NUM_CTR != iopm_pkg::NUM_CTR || NUM_PORTS != iopm_pkg::NUM_PORTS) begin : g_bad
      $error("iopm_monitor: NUM_CTR and NUM_PORTS must match the package");
   end

   iopm_pkg::iopm_state_t st_r;
   iopm_pkg::iopm_state_t st_nxt;

   // byte-lane merge for 32-bit writes
   function automatic logic [31:0] merge32(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0] sel);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // whether an event code may run on a given counter
   function automatic logic permitted(input logic [7:0] code, input int idx);
      logic ok;
      ok = 1'b1;
      case (code)
         iopm_pkg::EV_DBG_AND, iopm_pkg::EV_DBG_OR,
         iopm_pkg::EV_INB_DATA: ok = (idx < 2);            // RULE14 RULE20
         iopm_pkg::EV_OUTB_DATA, iopm_pkg::EV_OUTQ_OCC,
         iopm_pkg::EV_CBUF_OCC: ok = (idx >= 2);           // RULE15 RULE16 RULE19
         default: ok = 1'b1;
      endcase
      return ok;
   endfunction

   // raw per-cycle increment of the selected event, before filtering
   function automatic logic [iopm_pkg::INC_W-1:0] raw_inc(input logic [7:0] code,
                                                          input iopm_pkg::iopm_events_t ev);
      logic [iopm_pkg::INC_W-1:0] v;
      v = '0;
      case (code)
         iopm_pkg::EV_CLOCKS: v = 11'h001;                                   // RULE13 RULE23
         iopm_pkg::EV_INB_DATA: v = ev.inbound_data_request_event;          // RULE14
         iopm_pkg::EV_INB_TXN: v = {10'h000, ev.inbound_transaction_event}; // RULE22
         iopm_pkg::EV_INB_REQ: v = {10'h000, ev.inbound_request_count_event}; // RULE22
         iopm_pkg::EV_ARB_REQ: v = {10'h000, ev.ingress_arbitration_event}; // RULE17
         iopm_pkg::EV_ARB_WON: v = {10'h000, ev.ingress_grant_event};       // RULE17
         iopm_pkg::EV_PASS_CMPL: v = {10'h000, ev.pass_done_event};         // RULE21
         iopm_pkg::EV_CL_CMPL: v = {10'h000, ev.line_done_event};           // RULE21
         iopm_pkg::EV_REQ_CMPL: v = {10'h000, ev.pcie_request_done_event};  // RULE21
         iopm_pkg::EV_OUTB_DATA: v = ev.outbound_data_request_event;        // RULE15
         iopm_pkg::EV_CBUF_INS: v = {10'h000, ev.cbuf_insert_event};        // RULE19
         iopm_pkg::EV_OUTQ_OCC: v = {2'h0, ev.outbound_queue_occupancy_event}; // RULE16
         iopm_pkg::EV_LINE_REQ: v = {10'h000, ev.egress_line_request_event}; // RULE18
         iopm_pkg::EV_PKT_REQ: v = {10'h000, ev.egress_packet_request_event}; // RULE18
         iopm_pkg::EV_CBUF_OCC: v = {2'h0, ev.cbuf_occupancy_event};        // RULE19
         iopm_pkg::EV_DBG_AND: v = {10'h000, ev.dbg_and_match};             // RULE20
         iopm_pkg::EV_DBG_OR: v = {10'h000, ev.dbg_or_match};               // RULE20
         default: v = '0;                                                   // includes 0x80
      endcase
      return v;
   endfunction

   // events tagged with flow class and channel honour those filters
   function automatic logic is_filtered(input logic [7:0] code);
      logic f;
      case (code)
         iopm_pkg::EV_INB_TXN, iopm_pkg::EV_INB_REQ, iopm_pkg::EV_ARB_REQ,
         iopm_pkg::EV_ARB_WON, iopm_pkg::EV_PASS_CMPL, iopm_pkg::EV_CL_CMPL,
         iopm_pkg::EV_REQ_CMPL: f = 1'b1;
         default: f = 1'b0;
      endcase
      return f;
   endfunction

   // increment a programmable counter takes this cycle
   function automatic logic [iopm_pkg::INC_W-1:0] ctr_inc(input logic [63:0] ctl,
                                                          input int idx,
                                                          input iopm_pkg::iopm_events_t ev);
      logic [7:0] code;
      logic [iopm_pkg::INC_W-1:0] v;
      logic [iopm_pkg::THR_W-1:0] thr;
      logic [iopm_pkg::CH_W-1:0] chm;
      logic [iopm_pkg::FC_W-1:0] fc;
      logic [15:0] chx;
      code = ctl[iopm_pkg::EVSEL_LSB +: iopm_pkg::EVSEL_W];
      thr = ctl[iopm_pkg::THR_LSB +: iopm_pkg::THR_W];
      chm = ctl[iopm_pkg::CH_LSB +: iopm_pkg::CH_W];
      fc = ctl[iopm_pkg::FC_LSB +: iopm_pkg::FC_W];
      // channel tags past the mask width are never selected, so pad with zeros
      chx = 16'(chm);
      v = raw_inc(code, ev);
      if (!ctl[iopm_pkg::EN_BIT] || !permitted(code, idx)) begin
         v = '0;                                                     // RULE25
      end
      if (is_filtered(code)) begin
         if (fc != {1'b0, ev.flow_class}) begin
            v = '0;                                                  // RULE3
         end
         if (chm != '0 && !chx[ev.channel]) begin
            v = '0;                                                  // RULE4
         end
      end
      if (thr != '0 && {1'b0, v} < thr) begin
         v = '0;                                                     // RULE5
      end
      return v;
   endfunction

   // bandwidth accumulation: bytes fold into a 32-byte remainder
   function automatic logic [iopm_pkg::BW_W+iopm_pkg::BW_UNIT_LOG2-1:0] bw_step(
         input logic [iopm_pkg::BW_W-1:0] cnt,
         input logic [iopm_pkg::BW_UNIT_LOG2-1:0] rem,
         input logic [6:0] bytes);
      logic [7:0] sum;
      logic [iopm_pkg::BW_W-1:0] c;
      sum = {3'h0, rem} + {1'b0, bytes};
      c = cnt + {{(iopm_pkg::BW_W-3){1'b0}}, sum[7:iopm_pkg::BW_UNIT_LOG2]};
      return {c, sum[iopm_pkg::BW_UNIT_LOG2-1:0]};
   endfunction

   logic bus_req;
   logic bus_wr;
   logic [6:0] widx;
   assign bus_req = WB_CYC_I & WB_STB_I;
   // a write lands on the edge where the master sees ack high
   assign bus_wr = bus_req & WB_WE_I & st_r.ack;
   assign widx = WB_ADR_I;

   // next state: counting, bus writes and read data capture
   always_comb begin
      logic [31:0] rd;
      logic [63:0] c64;
      st_nxt = st_r;
      rd = '0;
      c64 = '0;
      // power-down level crosses in through two flops
      st_nxt.pd_meta = STACK_POWER_DOWN;
      st_nxt.pd = st_r.pd_meta;
      st_nxt.ack = bus_req & ~st_r.ack;
      if (!st_r.pd) begin                                            // RULE8
         st_nxt.ioclk = st_r.ioclk + 48'h1;                          // RULE9
         for (int c = 0; c < iopm_pkg::NUM_CTR; c++) begin
            // 48-bit add wraps naturally
            st_nxt.ctr[c] = st_r.ctr[c] +
               {{(iopm_pkg::CTR_W-iopm_pkg::INC_W){1'b0}}, ctr_inc(st_r.ctl[c], c, EVENTS)}; // RULE1 RULE2 RULE24
         end
         for (int p = 0; p < iopm_pkg::NUM_PORTS; p++) begin
            {st_nxt.bw_in[p], st_nxt.rem_in[p]} =
               bw_step(st_r.bw_in[p], st_r.rem_in[p], BW_IN_BYTES[p]);   // RULE10
            {st_nxt.bw_out[p], st_nxt.rem_out[p]} =
               bw_step(st_r.bw_out[p], st_r.rem_out[p], BW_OUT_BYTES[p]); // RULE11
         end
      end
      // software writes reach control and programmable counters only
      if (bus_wr) begin                                              // RULE7
         if (widx[6:3] == iopm_pkg::IDX_CTL[6:3]) begin
            c64 = st_r.ctl[widx[2:1]];
            if (widx[0]) begin
               c64[63:32] = merge32(c64[63:32], WB_DAT_I, WB_SEL_I);
            end else begin
               c64[31:0] = merge32(c64[31:0], WB_DAT_I, WB_SEL_I);
            end
            st_nxt.ctl[widx[2:1]] = c64 & iopm_pkg::CTL_WMASK;       // RULE6
         end else if (widx[6:3] == iopm_pkg::IDX_CTR[6:3]) begin
            c64 = {16'h0000, st_r.ctr[widx[2:1]]};
            if (widx[0]) begin
               c64[63:32] = merge32(c64[63:32], WB_DAT_I, WB_SEL_I);
            end else begin
               c64[31:0] = merge32(c64[31:0], WB_DAT_I, WB_SEL_I);
            end
            st_nxt.ctr[widx[2:1]] = c64[iopm_pkg::CTR_W-1:0];
         end
      end
      // read mux, captured with ack; unmapped words read zero
      // a 64-bit value is read one half at a time, so a running count
      // may tear between halves; software rereads the high half to spot it
      if (widx[6:3] == iopm_pkg::IDX_CTL[6:3]) begin
         c64 = st_r.ctl[widx[2:1]];
         rd = widx[0] ? c64[63:32] : c64[31:0];
      end else if (widx[6:3] == iopm_pkg::IDX_CTR[6:3]) begin
         c64 = {16'h0000, st_r.ctr[widx[2:1]]};
         rd = widx[0] ? c64[63:32] : c64[31:0];
      end else if (widx[6:1] == iopm_pkg::IDX_IOCLK[6:1]) begin
         c64 = {16'h0000, st_r.ioclk};
         rd = widx[0] ? c64[63:32] : c64[31:0];
      end else if (widx[6:4] == iopm_pkg::IDX_BWIN[6:4]) begin
         c64 = {28'h0000000, st_r.bw_in[widx[3:1]]};                 // RULE12
         rd = widx[0] ? c64[63:32] : c64[31:0];
      end else if (widx[6:4] == iopm_pkg::IDX_BWOUT[6:4]) begin
         c64 = {28'h0000000, st_r.bw_out[widx[3:1]]};                // RULE12
         rd = widx[0] ? c64[63:32] : c64[31:0];
      end else if (widx == iopm_pkg::IDX_STATUS) begin
         rd[iopm_pkg::STATUS_PD_BIT] = st_r.pd;
      end
      if (bus_req & ~st_r.ack) begin
         st_nxt.dat = rd;
      end
   end

   // single state register
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         st_r <= '0;
         for (int c = 0; c < iopm_pkg::NUM_CTR; c++) begin
            st_r.ctl[c] <= iopm_pkg::CTL_RESET;
         end
      end else begin
         st_r <= st_nxt;
      end
   end

   assign WB_ACK_O = st_r.ack;
   assign WB_DAT_O = st_r.dat;
   assign STACK_POWERED_DOWN = st_r.pd;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);

   logic ctl0_clk;
   logic ctl0_bad;
   logic ctr_wr;
   logic [7:0] ctl0_code;
   assign ctl0_code = st_r.ctl[0][iopm_pkg::EVSEL_LSB +: iopm_pkg::EVSEL_W];
   assign ctl0_clk = ctl0_code == iopm_pkg::EV_CLOCKS && st_r.ctl[0][iopm_pkg::EN_BIT];
   // every code barred from counter 0, not just one of them
   assign ctl0_bad = ctl0_code == iopm_pkg::EV_OUTB_DATA || ctl0_code == iopm_pkg::EV_OUTQ_OCC
                     || ctl0_code == iopm_pkg::EV_CBUF_OCC;
   assign ctr_wr = bus_wr && widx[6:3] == iopm_pkg::IDX_CTR[6:3];

   // sampled reset keeps the release edge out: the state is still held there
   chk_ioclk_step: assert property ( // RULE9
      !RESET && !st_r.pd |=> st_r.ioclk == $past(st_r.ioclk) + 48'h1)
      else $error("io clock counter did not step");
   chk_powerdown_hold: assert property (st_r.pd && !ctr_wr |=>
      st_r.ctr[0] == $past(st_r.ctr[0]) && st_r.bw_in[0] == $past(st_r.bw_in[0])) // RULE8
      else $error("counting while powered down");
   chk_clock_event: assert property (ctl0_clk && !st_r.pd && !ctr_wr && !bus_wr |=>
      st_r.ctr[0] == $past(st_r.ctr[0]) + 48'h1) // RULE13
      else $error("clock event did not add one");
   chk_forbidden_code: assert property (ctl0_bad && !ctr_wr |=> $stable(st_r.ctr[0])) // RULE25
      else $error("forbidden event counted");
   // a 31-byte remainder plus 127 new bytes carries at most four units
   chk_bw_step: assert property (##1 (st_r.bw_in[0] - $past(st_r.bw_in[0])) <= 36'h4) // RULE10
      else $error("inbound bandwidth jumped");
   chk_bw_out_step: assert property (st_r.pd |=> $stable(st_r.bw_out[0])) // RULE11
      else $error("outbound bandwidth moved while powered down");
   chk_ioclk_ro: assert property (bus_wr && widx[6:1] == iopm_pkg::IDX_IOCLK[6:1] && !st_r.pd
      |=> st_r.ioclk == $past(st_r.ioclk) + 48'h1) // RULE7
      else $error("write disturbed io clock counter");
   chk_ack_pulse: assert property (bus_req && !WB_ACK_O |=> WB_ACK_O ##1 !WB_ACK_O)
      else $error("ack not a single cycle");
   chk_reserved_zero: assert property (st_r.ctl[1][63:51] == 13'h0000) // RULE6
      else $error("reserved control bits stored");
   // the power-down level crosses two flops before counting sees it
   chk_pd_sync: assert property ( // RULE8
      STACK_POWER_DOWN ##1 STACK_POWER_DOWN |=> STACK_POWERED_DOWN)
      else $error("power-down level not synchronised");
   // ack only answers a request, it never stands on its own
   chk_ack_no_req: assert property (!bus_req |=> !WB_ACK_O)
      else $error("ack without a request");

endmodule

`default_nettype wire

// ==== sim/iopm_traffic_model.sv ====
/*
 * iopm_traffic_model: behavioural traffic controller feeding the monitor's
 * event and bandwidth inputs.
 * Assumes the bench changes its controls just after a rising clock edge.
 */
`timescale 1ns/1ns
`default_nettype none

module iopm_traffic_model (
   input wire logic act,
   input wire logic [10:0] inc,
   input wire logic [1:0] fl,
   input wire logic [3:0] chn,
   input wire logic [6:0] bytes,
   output iopm_pkg::iopm_events_t ev,
   output logic [7:0][6:0] bw_in,
   output logic [7:0][6:0] bw_out
);
   // every event fires while active; idle means no traffic at all
   always_comb begin
      ev = '0;
      bw_in = '0;
      bw_out = '0;
      if (act) begin
         ev = '{inc, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, inc, 1'b1, inc[8:0],
            1'b1, 1'b1, inc[8:0], 1'b1, 1'b1, fl, chn};
         // outbound carries half the inbound bytes so the two counts differ
         bw_in = {8{bytes}};
         bw_out = {8{1'b0, bytes[6:1]}};
      end
   end
endmodule

`default_nettype wire

// ==== sim/tb_top.sv ====
/*
 * tb_top: self-checking bench for the performance monitor; bandwidth and
 * free-running clock tests, then table of event cases, wrap and power-down tests.
 * Assumes the package constants and the Wishbone timing of the monitor.
 */
`timescale 1ns/1ns
`default_nettype none

module tb_top;
   typedef struct {int c; logic [7:0] ev; logic [11:0] thr; logic [11:0] ch; logic [2:0] fc;
      logic [10:0] inc; logic [1:0] fl; logic [3:0] chn; logic [47:0] exp;} iopm_row_t;
   logic clk, rst, cyc, stb, we, ack, pd, pdo, act;
   logic [6:0] adr, bytes;
   logic [3:0] sel, chn;
   logic [1:0] fl;
   logic [10:0] inc;
   logic [31:0] wdat, rdat, tk, tc, a, b, ta;
   logic [7:0][6:0] bwi, bwo;
   iopm_pkg::iopm_events_t ev;
   iopm_row_t r;
   int err_count, checked;
   // one four-cycle burst per row, so expected counts are four times the increment
   iopm_row_t rows [30] = '{
      '{0, 8'h83, '0, '0, '0, 11'h400, '0, '0, 48'h1000},
      '{2, 8'h83, '0, '0, '0, 11'h400, '0, '0, 48'h0},
      '{2, 8'hC0, '0, '0, '0, 11'h400, '0, '0, 48'h1000},
      '{1, 8'hC0, '0, '0, '0, 11'h400, '0, '0, 48'h0},
      '{3, 8'hC5, '0, '0, '0, 11'h100, '0, '0, 48'h400},
      '{0, 8'hC5, '0, '0, '0, 11'h100, '0, '0, 48'h0},
      '{2, 8'hD5, '0, '0, '0, 11'h100, '0, '0, 48'h400},
      '{1, 8'hD5, '0, '0, '0, 11'h100, '0, '0, 48'h0},
      '{3, 8'hC2, '0, '0, '0, '0, '0, '0, 48'h4},
      '{0, 8'h86, '0, '0, '0, '0, '0, '0, 48'h4},
      '{1, 8'h87, '0, '0, '0, '0, '0, '0, 48'h4},
      '{2, 8'hD0, '0, '0, '0, '0, '0, '0, 48'h4},
      '{3, 8'hD1, '0, '0, '0, '0, '0, '0, 48'h4},
      '{0, 8'h90, '0, '0, '0, '0, '0, '0, 48'h4},
      '{1, 8'h91, '0, '0, '0, '0, '0, '0, 48'h4},
      '{2, 8'h92, '0, '0, '0, '0, '0, '0, 48'h4},
      '{3, 8'h84, '0, '0, '0, '0, '0, '0, 48'h4},
      '{0, 8'h85, '0, '0, '0, '0, '0, '0, 48'h4},
      '{0, 8'h02, '0, '0, '0, '0, '0, '0, 48'h4},
      '{1, 8'h03, '0, '0, '0, '0, '0, '0, 48'h4},
      '{3, 8'h02, '0, '0, '0, '0, '0, '0, 48'h0},
      '{1, 8'h84, '0, '0, 3'h1, '0, 2'h1, '0, 48'h4},
      '{1, 8'h84, '0, '0, 3'h0, '0, 2'h2, '0, 48'h0},
      '{2, 8'h90, '0, '0, 3'h2, '0, 2'h2, '0, 48'h4},
      '{2, 8'h86, '0, 12'h010, '0, '0, '0, 4'h4, 48'h4},
      '{2, 8'h86, '0, 12'h010, '0, '0, '0, 4'h5, 48'h0},
      '{0, 8'h83, 12'h064, '0, '0, 11'h063, '0, '0, 48'h0},
      '{0, 8'h83, 12'h064, '0, '0, 11'h064, '0, '0, 48'h190},
      '{2, 8'h86, '0, 12'hFFF, '0, '0, '0, 4'hC, 48'h0},
      '{1, 8'h80, '0, '0, '0, 11'h400, '0, '0, 48'h0}};

   iopm_monitor i_iopm_monitor (.CLK(clk), .RESET(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
      .WB_ACK_O(ack), .EVENTS(ev), .BW_IN_BYTES(bwi), .BW_OUT_BYTES(bwo),
      .STACK_POWER_DOWN(pd), .STACK_POWERED_DOWN(pdo));
   iopm_traffic_model i_iopm_traffic_model (.act(act), .inc(inc), .fl(fl), .chn(chn),
      .bytes(bytes), .ev(ev), .bw_in(bwi), .bw_out(bwo));

   // clock and a cycle stamp used to time free-running reads
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) tc <= tc + 32'h1;

   task automatic conclude();
      $display("checked %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] s);
      checked++;
      if (s !== e) begin
         $display("[ERR] %s expected %h seen %h", nm, e, s);
         err_count++;
      end
   endtask

   // one classic cycle; tk stamps the edge that takes the request
   task automatic wb(input logic w, input logic [6:0] ad, input logic [31:0] d,
      output logic [31:0] q);
      int n;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= ad;
      wdat <= d;
      @(posedge clk);
      tk = tc;
      n = 0;
      while (ack !== 1'b1 && n < 16) begin
         @(posedge clk);
         n++;
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      if (n >= 16) begin
         err_count++;
         conclude();
      end
   endtask

   task automatic rd(input logic [6:0] ad, output logic [31:0] q);
      wb(1'b0, ad, 32'h0, q);
   endtask

   task automatic wr(input logic [6:0] ad, input logic [31:0] d);
      logic [31:0] x;
      wb(1'b1, ad, d, x);
   endtask

   task automatic burst(input int n);
      @(posedge clk);
      act <= 1'b1;
      repeat (n) @(posedge clk);
      act <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   // two timed reads; count moved must equal edges elapsed (or zero when held)
   task automatic delta(input string nm, input logic [6:0] ad, input logic held);
      logic [31:0] x, y, t;
      rd(ad, x);
      t = tk;
      rd(ad, y);
      chk(nm, held ? 48'h0 : 48'(tk - t), 48'(y - x));
   endtask

   task automatic run(input iopm_row_t q, input logic [47:0] init);
      logic [63:0] ctl;
      logic [31:0] lo, hi;
      logic [6:0] ci;
      ci = 7'(2 * q.c);
      // reserved bits 63:51 always written as zero
      ctl = {13'h0, q.fc, q.ch, q.thr, 1'b0, 1'b1, 14'h0, q.ev};
      inc <= q.inc;
      fl <= q.fl;
      chn <= q.chn;
      wr(iopm_pkg::IDX_CTL + ci, ctl[31:0]);
      wr(iopm_pkg::IDX_CTL + ci + 7'h1, ctl[63:32]);
      wr(iopm_pkg::IDX_CTR + ci, init[31:0]);
      wr(iopm_pkg::IDX_CTR + ci + 7'h1, {16'h0, init[47:32]});
      burst(4);
      rd(iopm_pkg::IDX_CTR + ci, lo);
      rd(iopm_pkg::IDX_CTR + ci + 7'h1, hi);
      chk($sformatf("counter %0d event %h", q.c, q.ev), q.exp, {hi[15:0], lo});
      $display("test counter %0d event %h done", q.c, q.ev);
   endtask

   initial begin
      err_count = 0;
      checked = 0;
      tc = 32'h0;
      rst = 1'b1;
      {cyc, stb, we, pd, act} = 5'h0;
      adr = 7'h0;
      sel = 4'hF;
      wdat = 32'h0;
      inc = 11'h0;
      fl = 2'h0;
      chn = 4'h0;
      bytes = 7'h0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      rd(iopm_pkg::IDX_CTL, a);
      chk("control reset", 48'h0, 48'(a));
      // 40 bytes per cycle for four cycles: 160 in, 80 out
      bytes <= 7'h28;
      burst(4);
      bytes <= 7'h00;
      rd(iopm_pkg::IDX_BWIN, a);
      chk("bw in p0", 48'h5, 48'(a));
      rd(iopm_pkg::IDX_BWIN + 7'hE, a);
      chk("bw in p7", 48'h5, 48'(a));
      wr(iopm_pkg::IDX_BWOUT + 7'h6, 32'hFFFF_FFFF);
      rd(iopm_pkg::IDX_BWOUT + 7'h6, a);
      chk("bw out p3", 48'h2, 48'(a));
      rd(iopm_pkg::IDX_BWOUT + 7'h7, a);
      chk("bw out p3 high", 48'h0, 48'(a));
      rd(7'h7F, a);
      chk("unmapped", 48'h0, 48'(a));
      $display("test bandwidth done");
      // a write in between must not disturb the free-running clock count
      rd(iopm_pkg::IDX_IOCLK, a);
      ta = tk;
      wr(iopm_pkg::IDX_IOCLK, 32'h0);
      rd(iopm_pkg::IDX_IOCLK, b);
      chk("io clock", 48'(tk - ta), 48'(b - a));
      $display("test io clock done");
      foreach (rows[i]) run(rows[i], 48'h0);
      r = '{0, 8'h83, '0, '0, '0, 11'h001, '0, '0, 48'h2};
      run(r, 48'hFFFF_FFFF_FFFE);
      for (int c = 0; c < 4; c++) begin
         wr(iopm_pkg::IDX_CTL + 7'(2 * c), 32'h0040_0081);
         wr(iopm_pkg::IDX_CTL + 7'(2 * c + 1), 32'h0);
         delta($sformatf("clock event %0d", c), iopm_pkg::IDX_CTR + 7'(2 * c), 1'b0);
      end
      $display("test clock event done");
      // power down freezes everything, power up resumes from held values
      pd <= 1'b1;
      repeat (4) @(posedge clk);
      chk("powered down", 48'h1, 48'(pdo));
      rd(iopm_pkg::IDX_STATUS, a);
      chk("status powered down", 48'h1, 48'(a));
      delta("held counter", iopm_pkg::IDX_CTR + 7'h6, 1'b1);
      delta("held io clock", iopm_pkg::IDX_IOCLK, 1'b1);
      pd <= 1'b0;
      repeat (4) @(posedge clk);
      delta("resumed counter", iopm_pkg::IDX_CTR + 7'h6, 1'b0);
      $display("test power down done");
      // reset in mid-run: io clock restarts, controls and counters clear
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd(iopm_pkg::IDX_IOCLK, a);
      chk("io clock after reset", 48'h1, 48'(a));
      rd(iopm_pkg::IDX_CTL + 7'h6, a);
      chk("control after reset", 48'h0, 48'(a));
      rd(iopm_pkg::IDX_CTR + 7'h6, a);
      chk("counter after reset", 48'h0, 48'(a));
      $display("test mid-run reset done");
      conclude();
   end

   // hang guard
   initial begin
      repeat (100000) @(posedge clk);
      err_count++;
      conclude();
   end
endmodule

`default_nettype wire
